// File: vpw_pkg.sv
package vpw_pkg;
	localparam int MCLK_HZ = 125_000_000;
	localparam int FILT_HZ = 1_048_600;
	localparam int FILT_DIV = MCLK_HZ / FILT_HZ;
	localparam int DIV_W = 7;
	localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(FILT_DIV - 1);
	localparam int TICK_W = 9;
	localparam logic [3:0] FILT_TOP = 4'hF;
	localparam logic [3:0] FILT_BOT = 4'h0;
	localparam logic PASSIVE = 1'b0;
	localparam logic ACTIVE = 1'b1;
	localparam int SHORT_US = 64;
	localparam int LONG_US = 128;
	localparam int SOF_US = 200;
	localparam int EOD_US = 200;
	localparam int EOF_US = 280;
	localparam int IFS_US = 300;
	localparam int MIN_SYM_US = 32;
	localparam int STABLE_US = 100;
	function automatic logic [TICK_W-1:0] us_ticks(input int us);
		longint t;
		t = longint'(us) * FILT_HZ / 1_000_000;
		return t[TICK_W-1:0];
	endfunction
	localparam logic [TICK_W-1:0] SHORT_T = us_ticks(SHORT_US);
	localparam logic [TICK_W-1:0] LONG_T = us_ticks(LONG_US);
	localparam logic [TICK_W-1:0] SOF_T = us_ticks(SOF_US);
	localparam logic [TICK_W-1:0] EOD_T = us_ticks(EOD_US);
	localparam logic [TICK_W-1:0] EOF_T = us_ticks(EOF_US);
	localparam logic [TICK_W-1:0] IFS_T = us_ticks(IFS_US);
	localparam logic [TICK_W-1:0] MIN_SYM_T = us_ticks(MIN_SYM_US);
	localparam logic [TICK_W-1:0] STABLE_T = us_ticks(STABLE_US);
	localparam int MAX_BYTES = 12;
	localparam logic [3:0] LAST_DATA = 4'(MAX_BYTES - 1);
	localparam logic [7:0] CRC_POLY = 8'h1D;
	localparam logic [7:0] CRC_INIT = 8'hFF;
	typedef enum logic [1:0] {
		MODE_RESET = 2'b00,
		MODE_RUN = 2'b01,
		MODE_WAIT = 2'b10,
		MODE_STOP = 2'b11
	} mode_e;
	function automatic logic [7:0] crc_byte(input logic [7:0] crc,
		input logic [7:0] d);
		logic [7:0] c;
		c = crc;
		for (int i = 7; i >= 0; i--) begin
			if (c[7] ^ d[i]) begin
				c = {c[6:0], 1'b0} ^ CRC_POLY;
			end else begin
				c = {c[6:0], 1'b0};
			end
		end
		return c;
	endfunction
endpackage

// File: filt_if.sv
`timescale 1ns/1ps
interface filt_if;
	logic tick;
	logic raw;
	logic filt;
	modport filt_side(input tick, input raw, output filt);
	modport user_side(output tick, output raw, input filt);
endinterface

// File: rx_noise_filter.sv
`timescale 1ns/1ps
module rx_noise_filter (
	input wire logic mclk,
	input wire logic rst,
	filt_if.filt_side fi
);
	typedef struct packed {
		logic smp;
		logic upd;
		logic [3:0] cnt;
		logic lat;
	} filt_s;
	filt_s r, n;

	always_comb begin
		n = r;
		n.upd = 1'b0;
		if (fi.tick) begin
			n.smp = fi.raw;
			n.upd = 1'b1;
		end
		// Counting one cycle after the sample stands in for the falling edge
		if (r.upd) begin
			if (r.smp && r.cnt != vpw_pkg::FILT_TOP) begin
				n.cnt = r.cnt + 4'h1;
			end else if (!r.smp && r.cnt != vpw_pkg::FILT_BOT) begin
				n.cnt = r.cnt - 4'h1;
			end
			if (n.cnt == vpw_pkg::FILT_TOP) begin
				n.lat = vpw_pkg::ACTIVE;
			end else if (n.cnt == vpw_pkg::FILT_BOT) begin
				n.lat = vpw_pkg::PASSIVE;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			r <= '{smp: vpw_pkg::PASSIVE, upd: 1'b0,
				cnt: vpw_pkg::FILT_BOT, lat: vpw_pkg::PASSIVE};
		end else begin
			r <= n;
		end
	end

	assign fi.filt = r.lat;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	property p_sample;
		fi.tick |=> r.upd && r.smp == $past(fi.raw);
	endproperty
	a_sample: assert property (p_sample) else $error("sample lost");
	property p_count;
		r.upd && r.smp && r.cnt != vpw_pkg::FILT_TOP
			|=> r.cnt == $past(r.cnt) + 4'h1;
	endproperty
	a_count: assert property (p_count) else $error("no count up");
	property p_sat;
		r.upd && !r.smp && r.cnt == vpw_pkg::FILT_BOT
			|=> r.cnt == vpw_pkg::FILT_BOT;
	endproperty
	a_sat: assert property (p_sat) else $error("counter underflow");
	property p_latch;
		$changed(r.lat) |-> r.cnt == vpw_pkg::FILT_TOP
			|| r.cnt == vpw_pkg::FILT_BOT;
	endproperty
	a_latch: assert property (p_latch) else $error("latch moved");
endmodule

// File: vpw_tx_framer.sv
`timescale 1ns/1ps
module vpw_tx_framer (
	input wire logic mclk,
	input wire logic rst,
	input wire logic tick,
	input wire logic start_ok,
	input wire logic [7:0] byte_data,
	input wire logic byte_valid,
	input wire logic byte_last,
	output logic byte_ready,
	output logic tx_out,
	output logic busy,
	output logic len_err
);
	typedef enum logic [1:0] {
		F_IDLE = 2'b00,
		F_SOF = 2'b01,
		F_BIT = 2'b10,
		F_EOD = 2'b11
	} fr_e;
	typedef struct packed {
		fr_e st;
		logic [7:0] sh;
		logic [2:0] bitn;
		logic [7:0] crc;
		logic [3:0] nby;
		logic lvl;
		logic [vpw_pkg::TICK_W-1:0] tmr;
		logic is_crc;
		logic last;
		logic err;
	} fr_s;
	fr_s r, n;
	logic done, take;

	// Long when bit value differs from level: passive 1 and active 0
	function automatic logic [vpw_pkg::TICK_W-1:0] dur(input logic lng);
		return (lng ? vpw_pkg::LONG_T : vpw_pkg::SHORT_T) - 1'b1;
	endfunction

	assign done = tick && r.tmr == '0;
	// A byte is only taken at a byte boundary; no gaps exist on the wire
	assign byte_ready = (r.st == F_IDLE && start_ok)
		|| (r.st == F_BIT && done && r.bitn == 3'h7 && !r.is_crc
		&& !r.last && r.nby != vpw_pkg::LAST_DATA);
	assign take = byte_valid && byte_ready;

	always_comb begin
		n = r;
		n.err = 1'b0;
		if (tick && r.tmr != '0) begin
			n.tmr = r.tmr - 1'b1;
		end
		case (r.st)
		F_IDLE: begin
			if (take) begin
				n.st = F_SOF;
				n.sh = byte_data;
				n.crc = vpw_pkg::crc_byte(vpw_pkg::CRC_INIT, byte_data);
				n.nby = 4'h1;
				n.last = byte_last;
				n.is_crc = 1'b0;
				n.bitn = 3'h0;
				n.lvl = vpw_pkg::ACTIVE;
				n.tmr = vpw_pkg::SOF_T - 1'b1;
			end
		end
		F_SOF: begin
			if (done) begin
				n.st = F_BIT;
				n.lvl = vpw_pkg::PASSIVE;
				n.tmr = dur(r.sh[7] ^ vpw_pkg::PASSIVE);
			end
		end
		F_BIT: begin
			if (done) begin
				n.lvl = ~r.lvl;
				if (r.bitn != 3'h7) begin
					n.bitn = r.bitn + 3'h1;
					n.sh = {r.sh[6:0], 1'b0};
					n.tmr = dur(r.sh[6] ^ ~r.lvl);
				end else if (r.is_crc) begin
					n.st = F_EOD;
					n.tmr = vpw_pkg::EOD_T - 1'b1;
				end else begin
					n.bitn = 3'h0;
					if (take) begin
						n.sh = byte_data;
						n.crc = vpw_pkg::crc_byte(r.crc, byte_data);
						n.nby = r.nby + 4'h1;
						n.last = byte_last;
						n.tmr = dur(byte_data[7] ^ ~r.lvl);
					end else begin
						n.sh = ~r.crc;
						n.is_crc = 1'b1;
						n.nby = r.nby + 4'h1;
						n.err = !r.last && r.nby == vpw_pkg::LAST_DATA;
						n.tmr = dur(~r.crc[7] ^ ~r.lvl);
					end
				end
			end
		end
		F_EOD: begin
			if (done) begin
				n.st = F_IDLE;
			end
		end
		default: n.st = F_IDLE;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			r <= '{st: F_IDLE, lvl: vpw_pkg::PASSIVE, default: '0};
		end else begin
			r <= n;
		end
	end

	assign tx_out = r.lvl;
	assign busy = r.st != F_IDLE;
	assign len_err = r.err;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	property p_len;
		busy |-> r.nby <= 4'(vpw_pkg::MAX_BYTES);
	endproperty
	a_len: assert property (p_len) else $error("frame too long");
	property p_sof;
		r.st == F_SOF |-> tx_out == vpw_pkg::ACTIVE;
	endproperty
	a_sof: assert property (p_sof) else $error("start not active");
	property p_start;
		r.st == F_IDLE && !take |=> r.st == F_IDLE;
	endproperty
	a_start: assert property (p_start) else $error("empty frame");
endmodule

// File: vpw_link_modes.sv
`timescale 1ns/1ps
module vpw_link_modes #(
	parameter int NSRC = 4
) (
	input wire logic mclk,
	input wire logic srst,
	input wire logic [NSRC-1:0] reset_src,
	input wire logic cpu_wait,
	input wire logic cpu_stop,
	input wire logic wait_clock_mode_bit,
	input wire logic dloop_en,
	input wire logic aloop_en,
	input wire logic rx_digital_in,
	output logic tx_digital_out,
	input wire logic [7:0] tx_data,
	input wire logic tx_valid,
	input wire logic tx_last,
	output logic tx_ready,
	output logic tx_busy,
	output logic frame_len_err,
	output logic rx_filtered,
	output logic rx_ready,
	output logic invalid_symbol,
	output logic eof_seen,
	output logic bus_idle,
	output logic wake_irq,
	output vpw_pkg::mode_e mode
);
	typedef struct packed {
		vpw_pkg::mode_e mode;
		logic [vpw_pkg::DIV_W-1:0] div;
		logic tick;
		logic filt_d;
		logic [vpw_pkg::TICK_W-1:0] gap;
		logic in_frame;
		logic aloop_d;
		logic idle_wait;
		logic [vpw_pkg::TICK_W-1:0] stab;
		logic txp;
		logic irq;
		logic inv;
		logic eof;
	} top_s;
	localparam top_s TOP_RST = '{mode: vpw_pkg::MODE_RESET,
		txp: vpw_pkg::PASSIVE, default: '0};

	top_s r, n;
	filt_if fi ();
	logic src_any, sub_rst, tx_int, start_ok, filt;
	logic rx_raw, filt_rise, filt_edge, eof_evt;

	assign src_any = |reset_src;
	// Whole datapath held while in reset mode, so inputs are ignored
	assign sub_rst = srst || r.mode == vpw_pkg::MODE_RESET;
	assign rx_raw = dloop_en ? tx_int : rx_digital_in;
	assign filt = fi.filt;
	assign filt_edge = filt != r.filt_d;
	assign filt_rise = filt_edge && filt == vpw_pkg::ACTIVE;
	assign eof_evt = r.tick && filt == vpw_pkg::PASSIVE && r.in_frame
		&& r.gap == vpw_pkg::EOF_T;
	assign bus_idle = filt == vpw_pkg::PASSIVE && r.gap == vpw_pkg::IFS_T;
	// Host must keep transmissions finished before it leaves run mode
	assign start_ok = r.mode == vpw_pkg::MODE_RUN && !r.idle_wait
		&& bus_idle;

	assign fi.tick = r.tick;
	assign fi.raw = rx_raw;

	rx_noise_filter u_filt (
		.mclk(mclk),
		.rst(sub_rst),
		.fi(fi)
	);

	vpw_tx_framer u_tx (
		.mclk(mclk),
		.rst(sub_rst),
		.tick(r.tick),
		.start_ok(start_ok),
		.byte_data(tx_data),
		.byte_valid(tx_valid),
		.byte_last(tx_last),
		.byte_ready(tx_ready),
		.tx_out(tx_int),
		.busy(tx_busy),
		.len_err(frame_len_err)
	);

	always_comb begin
		n = r;
		n.tick = 1'b0;
		n.irq = 1'b0;
		n.inv = 1'b0;
		n.eof = 1'b0;
		// Filter clock is an enable; it halts with the clocks in stop mode
		if (r.mode != vpw_pkg::MODE_STOP) begin
			if (r.div == vpw_pkg::DIV_LAST) begin
				n.div = '0;
				n.tick = 1'b1;
			end else begin
				n.div = r.div + 1'b1;
			end
		end
		n.filt_d = filt;
		if (filt_edge) begin
			if (r.in_frame && r.gap < vpw_pkg::MIN_SYM_T) begin
				n.inv = 1'b1;
			end
			n.gap = '0;
			if (filt == vpw_pkg::ACTIVE) begin
				n.in_frame = 1'b1;
			end
		end else if (r.tick && r.gap != vpw_pkg::IFS_T) begin
			n.gap = r.gap + 1'b1;
		end
		if (eof_evt) begin
			n.eof = 1'b1;
			n.in_frame = 1'b0;
		end
		n.aloop_d = aloop_en;
		if (r.aloop_d && !aloop_en) begin
			n.idle_wait = 1'b1;
		end else if (bus_idle) begin
			n.idle_wait = 1'b0;
		end
		if (r.tick && r.stab != '0) begin
			n.stab = r.stab - 1'b1;
		end
		n.txp = dloop_en ? vpw_pkg::PASSIVE : tx_int;
		case (r.mode)
		vpw_pkg::MODE_RESET: begin
			n.mode = vpw_pkg::MODE_RUN;
		end
		vpw_pkg::MODE_RUN: begin
			if (cpu_stop || (cpu_wait && wait_clock_mode_bit)) begin
				n.mode = vpw_pkg::MODE_STOP;
			end else if (cpu_wait) begin
				n.mode = vpw_pkg::MODE_WAIT;
			end
		end
		vpw_pkg::MODE_WAIT: begin
			if (filt_rise || eof_evt) begin
				n.irq = 1'b1;
				n.mode = vpw_pkg::MODE_RUN;
			end
		end
		vpw_pkg::MODE_STOP: begin
			// Raw pin is watched here since the filter clock is halted
			if (rx_raw == vpw_pkg::ACTIVE) begin
				n.irq = 1'b1;
				n.mode = vpw_pkg::MODE_RUN;
				n.stab = vpw_pkg::STABLE_T;
			end
		end
		default: n.mode = vpw_pkg::MODE_RESET;
		endcase
		if (src_any) begin
			n = TOP_RST;
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			r <= TOP_RST;
		end else begin
			r <= n;
		end
	end

	assign tx_digital_out = r.txp;
	assign rx_filtered = filt;
	// Reception is unreliable until the restarted clocks settle
	assign rx_ready = r.mode == vpw_pkg::MODE_RUN && r.stab == '0;
	assign invalid_symbol = r.inv;
	assign eof_seen = r.eof;
	assign wake_irq = r.irq;
	assign mode = r.mode;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (srst);
	property p_rst_any;
		src_any |=> r.mode == vpw_pkg::MODE_RESET
			&& tx_digital_out == vpw_pkg::PASSIVE && !wake_irq;
	endproperty
	a_rst_any: assert property (p_rst_any) else $error("no reset");
	property p_leave_rst;
		r.mode == vpw_pkg::MODE_RESET && !src_any
			|=> r.mode == vpw_pkg::MODE_RUN;
	endproperty
	a_leave_rst: assert property (p_leave_rst) else $error("stuck");
	property p_wait;
		r.mode == vpw_pkg::MODE_RUN && cpu_wait && !wait_clock_mode_bit
			&& !cpu_stop && !src_any |=> r.mode == vpw_pkg::MODE_WAIT
			##0 r.mode != vpw_pkg::MODE_STOP;
	endproperty
	a_wait: assert property (p_wait) else $error("no wait mode");
	property p_wake_edge;
		r.mode == vpw_pkg::MODE_WAIT && filt_rise && !src_any
			|=> wake_irq && r.mode == vpw_pkg::MODE_RUN ##1 !wake_irq;
	endproperty
	a_wake_edge: assert property (p_wake_edge) else $error("no wake");
	property p_wake_eof;
		r.mode == vpw_pkg::MODE_WAIT && eof_evt && !src_any
			|=> wake_irq && eof_seen;
	endproperty
	a_wake_eof: assert property (p_wake_eof) else $error("eof no wake");
	property p_stop;
		r.mode == vpw_pkg::MODE_RUN && !src_any
			&& (cpu_stop || (cpu_wait && wait_clock_mode_bit))
			|=> r.mode == vpw_pkg::MODE_STOP ##1 !r.tick;
	endproperty
	a_stop: assert property (p_stop) else $error("no stop mode");
	property p_stop_wake;
		r.mode == vpw_pkg::MODE_STOP && rx_raw == vpw_pkg::ACTIVE
			&& !src_any
			|=> wake_irq && r.mode == vpw_pkg::MODE_RUN && !rx_ready;
	endproperty
	a_stop_wake: assert property (p_stop_wake) else $error("no wake");
	property p_dloop;
		dloop_en |=> tx_digital_out == vpw_pkg::PASSIVE;
	endproperty
	a_dloop: assert property (p_dloop) else $error("bus driven");
	property p_aloop;
		$fell(aloop_en) && !src_any |=> r.idle_wait ##0 !start_ok;
	endproperty
	a_aloop: assert property (p_aloop) else $error("no idle wait");
	property p_inv;
		invalid_symbol |-> $past(r.gap) < vpw_pkg::MIN_SYM_T;
	endproperty
	a_inv: assert property (p_inv) else $error("bad invalid flag");
	c_wait_wake: cover property (r.mode == vpw_pkg::MODE_WAIT ##1 wake_irq);
	c_stop_wake: cover property (r.mode == vpw_pkg::MODE_STOP ##1 wake_irq);
	c_inv: cover property (invalid_symbol);
	c_eof: cover property (eof_seen && tx_busy == 1'b0);
endmodule

// File: vpw_xcvr_model.sv
`timescale 1ns/1ps
module vpw_xcvr_model (
	input wire logic tx_pin,
	input wire logic far_active,
	output logic rx_pin
);
	// Passive bus is pulled low; our own drive echoes back like a real
	// transceiver, so the receiver also hears frames that we send
	assign rx_pin = tx_pin | far_active;
endmodule

// File: vpw_link_modes_rx_filter_test.sv
`timescale 1ns/1ps
module vpw_link_modes_rx_filter_test;
	localparam int DIV = vpw_pkg::FILT_DIV;
	localparam int LO = 14 * DIV;
	localparam int HI = 16 * DIV + 4;
	localparam int EOF_LO = 300 * DIV;
	localparam int EOF_HI = 312 * DIV;
	typedef struct {
		int width;
		logic pass;
	} row_t;
	row_t rows [3] = '{'{4 * DIV, 1'h0}, '{12 * DIV, 1'h0}, '{24 * DIV, 1'h1}};
	logic mclk, srst, cpu_wait, cpu_stop, wait_clock_mode_bit;
	logic dloop_en, aloop_en, rx_digital_in, tx_digital_out;
	logic tx_valid, tx_last, tx_ready, tx_busy, rx_filtered, rx_ready;
	logic wake_irq, far_active;
	logic frame_len_err, invalid_symbol, eof_seen, bus_idle;
	logic [3:0] reset_src;
	logic [7:0] tx_data;
	vpw_pkg::mode_e mode;
	int errors = 0;
	int total_checks = 0;
	int n, rise, fall, inv, eof_at, idle_at;

	vpw_link_modes dut_u (
		.mclk(mclk),
		.srst(srst),
		.reset_src(reset_src),
		.cpu_wait(cpu_wait),
		.cpu_stop(cpu_stop),
		.wait_clock_mode_bit(wait_clock_mode_bit),
		.dloop_en(dloop_en),
		.aloop_en(aloop_en),
		.rx_digital_in(rx_digital_in),
		.tx_digital_out(tx_digital_out),
		.tx_data(tx_data),
		.tx_valid(tx_valid),
		.tx_last(tx_last),
		.tx_ready(tx_ready),
		.tx_busy(tx_busy),
		.frame_len_err(frame_len_err),
		.rx_filtered(rx_filtered),
		.rx_ready(rx_ready),
		.invalid_symbol(invalid_symbol),
		.eof_seen(eof_seen),
		.bus_idle(bus_idle),
		.wake_irq(wake_irq),
		.mode(mode)
	);

	vpw_xcvr_model xcvr_u (
		.tx_pin(tx_digital_out),
		.far_active(far_active),
		.rx_pin(rx_digital_in)
	);

	always #4 mclk = ~mclk;

	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch %s expected %0h seen %0h", what, exp, seen);
		end
	endtask

	task automatic report_and_stop;
		if (errors == 0 && total_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task automatic ticks(input int k);
		repeat (k * DIV) @(posedge mclk);
	endtask

	task automatic instr(input logic wt, input logic st,
		input vpw_pkg::mode_e exp);
		@(posedge mclk);
		cpu_wait <= wt;
		cpu_stop <= st;
		@(posedge mclk);
		cpu_wait <= 1'h0;
		cpu_stop <= 1'h0;
		#1;
		check("mode", mode, exp);
	endtask

	// Far node goes active; wake must come as one pulse with run mode
	task automatic wake;
		n = 0;
		@(posedge mclk);
		far_active <= 1'h1;
		while (wake_irq !== 1'h1 && n < 20 * DIV) begin
			@(posedge mclk);
			#1;
			n++;
		end
		check("wake_irq", wake_irq, 1'h1);
		check("mode", mode, vpw_pkg::MODE_RUN);
		@(posedge mclk);
		far_active <= 1'h0;
		#1;
		check("wake_irq", wake_irq, 1'h0);
		ticks(18);
	endtask

	task automatic run_len(input logic lvl, input int lim, output int k);
		k = 0;
		while (tx_digital_out === lvl && k < lim) begin
			@(negedge mclk);
			k++;
		end
	endtask

	initial begin
		mclk = 1'h0;
		srst = 1'h1;
		reset_src = 4'h0;
		cpu_wait = 1'h0;
		cpu_stop = 1'h0;
		wait_clock_mode_bit = 1'h0;
		dloop_en = 1'h0;
		aloop_en = 1'h0;
		far_active = 1'h0;
		tx_data = 8'h00;
		tx_valid = 1'h0;
		tx_last = 1'h0;
		repeat (4) @(posedge mclk);
		srst <= 1'h0;
		#1;
		check("mode", mode, vpw_pkg::MODE_RESET);
		check("tx_digital_out", tx_digital_out, 1'h0);
		check("rx_filtered", rx_filtered, 1'h0);
		repeat (2) @(posedge mclk);
		#1;
		check("mode", mode, vpw_pkg::MODE_RUN);
		foreach (rows[i]) begin
			rise = 0;
			fall = 0;
			inv = 0;
			@(posedge mclk);
			far_active <= 1'h1;
			for (int c = 1; c <= rows[i].width + 17 * DIV; c++) begin
				@(posedge mclk);
				if (c == rows[i].width) begin
					far_active <= 1'h0;
				end
				@(negedge mclk);
				if (rise == 0 && rx_filtered === 1'h1) begin
					rise = c;
				end
				if (rise != 0 && fall == 0 && rx_filtered === 1'h0) begin
					fall = c;
				end
				if (invalid_symbol === 1'h1) begin
					inv = 1;
				end
			end
			check("passed", rise != 0, rows[i].pass);
			// Any pulse that passes here is shorter than the shortest symbol
			check("invalid_symbol", inv, rows[i].pass);
			if (rows[i].pass) begin
				check("rise_delay", rise >= LO && rise <= HI, 1'h1);
				fall = fall - rows[i].width;
				check("fall_delay", fall >= LO && fall <= HI, 1'h1);
			end
			check("rx_filtered", rx_filtered, 1'h0);
		end
		@(posedge mclk);
		reset_src <= 4'h4;
		far_active <= 1'h1;
		cpu_wait <= 1'h1;
		repeat (2) @(posedge mclk);
		cpu_wait <= 1'h0;
		#1;
		check("mode", mode, vpw_pkg::MODE_RESET);
		ticks(17);
		#1;
		check("rx_filtered", rx_filtered, 1'h0);
		@(posedge mclk);
		reset_src <= 4'h0;
		far_active <= 1'h0;
		repeat (2) @(posedge mclk);
		#1;
		check("mode", mode, vpw_pkg::MODE_RUN);
		ticks(2);
		instr(1'h1, 1'h0, vpw_pkg::MODE_WAIT);
		wake();
		@(posedge mclk);
		wait_clock_mode_bit <= 1'h1;
		instr(1'h1, 1'h0, vpw_pkg::MODE_STOP);
		wake();
		check("rx_ready", rx_ready, 1'h0);
		@(posedge mclk);
		wait_clock_mode_bit <= 1'h0;
		instr(1'h0, 1'h1, vpw_pkg::MODE_STOP);
		wake();
		@(posedge mclk);
		dloop_en <= 1'h1;
		far_active <= 1'h1;
		ticks(20);
		#1;
		check("rx_filtered", rx_filtered, 1'h0);
		check("tx_digital_out", tx_digital_out, 1'h0);
		@(posedge mclk);
		dloop_en <= 1'h0;
		aloop_en <= 1'h1;
		ticks(20);
		#1;
		check("rx_filtered", rx_filtered, 1'h1);
		// Wait mode on a busy bus, so the end of frame must wake us
		instr(1'h1, 1'h0, vpw_pkg::MODE_WAIT);
		// Leaving analog loopback on a busy bus must force a full idle wait
		@(posedge mclk);
		aloop_en <= 1'h0;
		far_active <= 1'h0;
		tx_data <= 8'h5A;
		tx_valid <= 1'h1;
		tx_last <= 1'h1;
		n = 0;
		eof_at = 0;
		idle_at = 0;
		do begin
			@(negedge mclk);
			n++;
			if (eof_seen === 1'h1) begin
				eof_at = n;
				check("wake_irq", wake_irq, 1'h1);
				check("mode", mode, vpw_pkg::MODE_RUN);
			end
			if (bus_idle === 1'h1 && idle_at == 0) begin
				idle_at = n;
			end
		end while (tx_ready !== 1'h1 && n < 400 * DIV);
		check("idle_wait", n >= 37000 && n < 400 * DIV, 1'h1);
		check("eof_seen", eof_at > EOF_LO && eof_at < EOF_HI, 1'h1);
		check("bus_idle", idle_at > eof_at && idle_at < n, 1'h1);
		check("rx_ready", rx_ready, 1'h1);
		@(posedge mclk);
		tx_valid <= 1'h0;
		run_len(1'h0, 8, n);
		check("sof_start", n <= 4, 1'h1);
		run_len(1'h1, 30000, n);
		check("sof_len", n > 24500 && n < 25500, 1'h1);
		check("tx_busy", tx_busy, 1'h1);
		// First data bit is a passive zero of the short width
		run_len(1'h0, 9000, n);
		check("bit7_len", n > 7700 && n < 8300, 1'h1);
		check("frame_len_err", frame_len_err, 1'h0);
		@(posedge mclk);
		srst <= 1'h1;
		@(posedge mclk);
		srst <= 1'h0;
		#1;
		check("tx_digital_out", tx_digital_out, 1'h0);
		check("mode", mode, vpw_pkg::MODE_RESET);
		report_and_stop();
	end

	// Whole run is near 98k cycles; a hang is cut just past that
	initial begin
		repeat (105000) @(posedge mclk);
		errors++;
		report_and_stop();
	end
endmodule
